// file: core/dsc_core.sv
// Control logic of the serially loaded 12-bit converter
// Summary of operation
// - Serial bits are accepted only while the active-low select is held low.
// - Each serial input bit is sampled on the serial clock rising edge.
// - Reset value select high picks midscale, low picks code zero.
// - Shutdown is refused while the lockout input is low.
// - Clear loads the converter with the selected reset code.
// - Clear also ends any software-commanded shutdown.
// - Power-down input high with lockout high enters shutdown.
// - In shutdown the analog output driver is high impedance.
// - Word is three control bits, twelve data bits MSB first, zero sub-bit.
// - Codes load input only, load both, or copy input to converter.
// - Dropping the power-down input does not end shutdown.
// - Lockout falling edge in shutdown wakes with the previous output value.
`timescale 1ns/10ps
`default_nettype none
module dsc_core import dsc_pkg::*; (
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        serial_clock,
	input  wire logic        chip_select_n,
	input  wire logic        serial_data_in,
	output logic             serial_data_out,
	input  wire logic        reset_value_select,
	input  wire logic        shutdown_lockout_n,
	input  wire logic        clear_to_reset_value,
	input  wire logic        power_down_request,
	output logic             user_general_output,
	output logic [11:0]      dac_code,
	output logic             analog_drive_en,
	output logic             in_shutdown,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic [15:0]      reg_rdata
);
	typedef struct packed {
		dsc_pwr_e    pwr;
		logic [1:0]  init_cnt;
		dsc_code_t   input_code;
		dsc_code_t   dac_code;
		logic        user_out;
		logic        out_on_rise;
		logic        lock_prev;
		logic        tog_prev;
		logic [15:0] ctrl;
		logic [15:0] rdata;
	} dsc_core_s;

	dsc_core_s s_q;
	dsc_core_s s_d;

	logic [15:0]          word_data;
	logic                 word_toggle;
	logic [DSC_PIN_N-1:0] pins_sync;
	logic                 resetsel_s;
	logic                 lock_s;
	logic                 clear_s;
	logic                 pwrdn_s;
	logic                 tog_s;
	logic                 word_evt;
	logic                 lock_fell;
	logic                 cmd_ok;
	logic                 sw_exit;
	logic                 sw_enter;
	logic [2:0]           cmd;
	dsc_code_t            data;
	dsc_code_t            reset_code;

	if (DSC_WORD_W != 16 || DSC_CODE_W != 12) begin : g_bad_width
		$error("dsc_core: serial word must be 16 bits and code 12 bits");
	end

	dsc_serial_link u_link (
		.serial_clock    (serial_clock),
		.link_rst        (sys_rst),
		.chip_select_n   (chip_select_n),
		.serial_data_in  (serial_data_in),
		.out_on_rise     (s_q.out_on_rise),
		.serial_data_out (serial_data_out),
		.word_data       (word_data),
		.word_toggle     (word_toggle)
	);

	// Strap and control pins plus the word-ready toggle
	dsc_sync #(
		.WIDTH (DSC_PIN_N)
	) u_sync (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.async_in ({word_toggle, power_down_request, clear_to_reset_value,
			shutdown_lockout_n, reset_value_select}),
		.sync_out (pins_sync)
	);

	assign resetsel_s = pins_sync[0];
	assign lock_s     = pins_sync[1];
	assign clear_s    = pins_sync[2];
	assign pwrdn_s    = pins_sync[3];
	assign tog_s      = pins_sync[4];

	function automatic dsc_code_t pick_reset_code(input logic sel);
		pick_reset_code = sel ? CODE_MIDSCALE : CODE_ZERO;
	endfunction

	// Word is held for sixteen serial clocks, far longer than the crossing
	assign word_evt   = tog_s ^ s_q.tog_prev;
	assign lock_fell  = s_q.lock_prev & !lock_s;
	assign cmd        = word_data[CMD_MSB:CMD_LSB];
	assign data       = word_data[DATA_MSB:DATA_LSB];
	assign cmd_ok     = word_evt & s_q.ctrl[CTRL_SERIAL_EN];
	assign reset_code = pick_reset_code(resetsel_s);

	always_comb begin
		s_d           = s_q;
		sw_exit       = 1'b0;
		sw_enter      = 1'b0;
		s_d.lock_prev = lock_s;
		s_d.tog_prev  = tog_s;
		s_d.rdata     = 16'h0000;
		case (s_q.pwr)
			PWR_INIT: begin
				s_d.init_cnt = s_q.init_cnt + 2'h1;
				if (s_q.init_cnt == INIT_WAIT) begin
					s_d.input_code = reset_code;
					s_d.dac_code   = reset_code;
					s_d.pwr        = PWR_ACTIVE;
				end
			end
			PWR_ACTIVE, PWR_SHUTDOWN: begin
				if (cmd_ok) begin
					case (cmd)
						CMD_LOAD_INPUT: begin
							s_d.input_code = data;
						end
						CMD_LOAD_BOTH: begin
							s_d.input_code = data;
							s_d.dac_code   = data;
							sw_exit        = 1'b1;
						end
						CMD_UPDATE: begin
							s_d.dac_code = s_q.input_code;
							sw_exit      = 1'b1;
						end
						CMD_SHUTDOWN: begin
							sw_enter = lock_s;
						end
						CMD_UOUT_LOW: begin
							s_d.user_out = 1'b0;
						end
						CMD_UOUT_HIGH: begin
							s_d.user_out = 1'b1;
						end
						CMD_DOUT_MODE: begin
							s_d.out_on_rise = word_data[MODE_BIT];
						end
						default: begin
							s_d.user_out = s_q.user_out;
						end
					endcase
				end
				if (sw_exit) begin
					s_d.pwr = PWR_ACTIVE;
				end
				// Pin level wins over a wake command in the same cycle
				if (sw_enter || (pwrdn_s && lock_s)) begin
					s_d.pwr = PWR_SHUTDOWN;
				end
				if (lock_fell && s_q.pwr == PWR_SHUTDOWN) begin
					s_d.pwr = PWR_ACTIVE;
				end
				if (clear_s) begin
					s_d.input_code = reset_code;
					s_d.dac_code   = reset_code;
					s_d.pwr        = PWR_ACTIVE;
				end
			end
			default: begin
				s_d.pwr = PWR_INIT;
			end
		endcase
		if (reg_write && reg_addr == REG_CTRL) begin
			s_d.ctrl = reg_wdata;
		end
		if (reg_read) begin
			case (reg_addr)
				REG_STATUS: begin
					s_d.rdata[ST_SHUTDOWN]  = s_q.pwr == PWR_SHUTDOWN;
					s_d.rdata[ST_UOUT]      = s_q.user_out;
					s_d.rdata[ST_DOUT_RISE] = s_q.out_on_rise;
					s_d.rdata[ST_LOCKOUT]   = lock_s;
					s_d.rdata[ST_RESETSEL]  = resetsel_s;
					s_d.rdata[ST_INIT]      = s_q.pwr == PWR_INIT;
				end
				REG_INPUT: begin
					s_d.rdata = {4'h0, s_q.input_code};
				end
				REG_DAC: begin
					s_d.rdata = {4'h0, s_q.dac_code};
				end
				REG_CTRL: begin
					s_d.rdata = s_q.ctrl;
				end
				default: begin
					s_d.rdata = 16'h0000;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_q      <= '0;
			s_q.pwr  <= PWR_INIT;
			s_q.ctrl <= CTRL_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign user_general_output = s_q.user_out;
	assign dac_code            = s_q.dac_code;
	assign in_shutdown         = s_q.pwr == PWR_SHUTDOWN;
	assign analog_drive_en     = s_q.pwr != PWR_SHUTDOWN;
	assign reg_rdata           = s_q.rdata;

	property p_lockout_refuses;
		@(posedge clock) disable iff (sys_rst)
		(!lock_s && s_q.pwr != PWR_SHUTDOWN) |=> (s_q.pwr != PWR_SHUTDOWN);
	endproperty
	a_lockout_refuses: assert property (p_lockout_refuses)
		else $error("shutdown entered while lockout low");

	property p_clear_loads;
		@(posedge clock) disable iff (sys_rst)
		(clear_s && s_q.pwr != PWR_INIT) |=> (dac_code == $past(reset_code));
	endproperty
	a_clear_loads: assert property (p_clear_loads)
		else $error("clear did not load reset code");

	property p_clear_wakes;
		@(posedge clock) disable iff (sys_rst)
		(clear_s && s_q.pwr != PWR_INIT) |=> !in_shutdown;
	endproperty
	a_clear_wakes: assert property (p_clear_wakes)
		else $error("clear did not leave shutdown");

	property p_pin_enters;
		@(posedge clock) disable iff (sys_rst)
		(pwrdn_s && lock_s && !clear_s && s_q.pwr != PWR_INIT) |=> in_shutdown;
	endproperty
	a_pin_enters: assert property (p_pin_enters)
		else $error("power-down pin did not enter shutdown");

	property p_drive_off;
		@(posedge clock) disable iff (sys_rst)
		$rose(in_shutdown) |-> (!analog_drive_en ##1 (in_shutdown == !analog_drive_en));
	endproperty
	a_drive_off: assert property (p_drive_off)
		else $error("output driven during shutdown");

	property p_input_only;
		@(posedge clock) disable iff (sys_rst)
		(cmd_ok && cmd == CMD_LOAD_INPUT && !clear_s && s_q.pwr != PWR_INIT)
		|=> ($stable(dac_code) && s_q.input_code == $past(data));
	endproperty
	a_input_only: assert property (p_input_only)
		else $error("input-only load disturbed converter code");

	property p_release_holds;
		@(posedge clock) disable iff (sys_rst)
		(in_shutdown && !pwrdn_s && lock_s && !clear_s && !word_evt) |=> in_shutdown;
	endproperty
	a_release_holds: assert property (p_release_holds)
		else $error("shutdown ended without wake cause");

	property p_lock_wakes;
		@(posedge clock) disable iff (sys_rst)
		(in_shutdown && lock_fell && !clear_s && !word_evt)
		|=> (!in_shutdown && $stable(dac_code));
	endproperty
	a_lock_wakes: assert property (p_lock_wakes)
		else $error("lockout fall did not wake with old code");

	property p_init_code;
		@(posedge clock) disable iff (sys_rst)
		(s_q.pwr == PWR_INIT && s_q.init_cnt == INIT_WAIT)
		|=> (dac_code == ($past(resetsel_s) ? CODE_MIDSCALE : CODE_ZERO))
		&& (s_q.input_code == dac_code);
	endproperty
	a_init_code: assert property (p_init_code)
		else $error("power-up code does not match reset select");

	property p_load_both;
		@(posedge clock) disable iff (sys_rst)
		(cmd_ok && cmd == CMD_LOAD_BOTH && !clear_s && s_q.pwr != PWR_INIT)
		|=> (dac_code == $past(data)) && (s_q.input_code == $past(data));
	endproperty
	a_load_both: assert property (p_load_both)
		else $error("load-both command did not load both registers");

	property p_update_copies;
		@(posedge clock) disable iff (sys_rst)
		(cmd_ok && cmd == CMD_UPDATE && !clear_s && s_q.pwr != PWR_INIT)
		|=> (dac_code == $past(s_q.input_code));
	endproperty
	a_update_copies: assert property (p_update_copies)
		else $error("update command did not copy the input register");

	property p_cmd_wakes;
		@(posedge clock) disable iff (sys_rst)
		(cmd_ok && (cmd == CMD_LOAD_BOTH || cmd == CMD_UPDATE) && !pwrdn_s
		&& s_q.pwr != PWR_INIT) |=> !in_shutdown;
	endproperty
	a_cmd_wakes: assert property (p_cmd_wakes)
		else $error("wake command did not leave shutdown");

	property p_soft_enter;
		@(posedge clock) disable iff (sys_rst)
		(cmd_ok && cmd == CMD_SHUTDOWN && lock_s && !clear_s && s_q.pwr != PWR_INIT)
		|=> in_shutdown;
	endproperty
	a_soft_enter: assert property (p_soft_enter)
		else $error("shutdown command ignored with lockout high");

	// Disabled command port must leave the converter code and user output alone
	property p_gate_off;
		@(posedge clock) disable iff (sys_rst)
		(word_evt && !s_q.ctrl[CTRL_SERIAL_EN] && !clear_s && s_q.pwr != PWR_INIT)
		|=> $stable(dac_code) && $stable(user_general_output);
	endproperty
	a_gate_off: assert property (p_gate_off)
		else $error("word acted on while commands disabled");

	property p_init_quiet;
		@(posedge clock) disable iff (sys_rst)
		(s_q.pwr == PWR_INIT && s_q.init_cnt != INIT_WAIT)
		|=> (s_q.pwr == PWR_INIT) && $stable(dac_code);
	endproperty
	a_init_quiet: assert property (p_init_quiet)
		else $error("power-up wait cut short");

	property p_select_gates;
		@(posedge serial_clock) disable iff (sys_rst)
		chip_select_n |=> $stable(word_toggle);
	endproperty
	a_select_gates: assert property (p_select_gates)
		else $error("word taken while select high");
endmodule // dsc_core
`default_nettype wire

// file: core/dsc_pkg.sv
// Constants and types shared by the serial converter control block
package dsc_pkg;

	localparam int DSC_WORD_W = 16;
	localparam int DSC_CODE_W = 12;
	localparam int DSC_PIN_N  = 5;

	// Serial word fields
	localparam int CMD_MSB  = 15;
	localparam int CMD_LSB  = 13;
	localparam int DATA_MSB = 12;
	localparam int DATA_LSB = 1;
	localparam int MODE_BIT = 12;

	localparam logic [4:0] LINK_BITS_FULL = 5'h10;
	localparam logic [4:0] LINK_BITS_LAST = 5'h0f;

	// Command codes in the top three bits
	localparam logic [2:0] CMD_NOP        = 3'h0;
	localparam logic [2:0] CMD_LOAD_INPUT = 3'h1;
	localparam logic [2:0] CMD_LOAD_BOTH  = 3'h2;
	localparam logic [2:0] CMD_UPDATE     = 3'h3;
	localparam logic [2:0] CMD_UOUT_LOW   = 3'h4;
	localparam logic [2:0] CMD_SHUTDOWN   = 3'h5;
	localparam logic [2:0] CMD_UOUT_HIGH  = 3'h6;
	localparam logic [2:0] CMD_DOUT_MODE  = 3'h7;

	localparam logic [11:0] CODE_MIDSCALE = 12'h800;
	localparam logic [11:0] CODE_ZERO     = 12'h000;

	// Cycles after reset before strap pins are trusted
	localparam logic [1:0] INIT_WAIT = 2'h3;

	// Register port map
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_INPUT  = 4'h1;
	localparam logic [3:0] REG_DAC    = 4'h2;
	localparam logic [3:0] REG_CTRL   = 4'h3;

	localparam int CTRL_SERIAL_EN = 0;
	localparam logic [15:0] CTRL_RESET = 16'h0001;

	localparam int ST_SHUTDOWN = 0;
	localparam int ST_UOUT     = 1;
	localparam int ST_DOUT_RISE = 2;
	localparam int ST_LOCKOUT  = 3;
	localparam int ST_RESETSEL = 4;
	localparam int ST_INIT     = 5;

	typedef enum logic [1:0] {PWR_INIT, PWR_ACTIVE, PWR_SHUTDOWN} dsc_pwr_e;

	typedef logic [DSC_CODE_W-1:0] dsc_code_t;

endpackage

// file: core/dsc_serial_link.sv
// Serial shift register on the host's serial clock
`timescale 1ns/10ps
`default_nettype none
module dsc_serial_link import dsc_pkg::*; (
	input  wire logic        serial_clock,
	input  wire logic        link_rst,
	input  wire logic        chip_select_n,
	input  wire logic        serial_data_in,
	input  wire logic        out_on_rise,
	output logic             serial_data_out,
	output logic [15:0]      word_data,
	output logic             word_toggle
);
	typedef struct packed {
		logic [15:0] shift;
		logic [15:0] word;
		logic        toggle;
		logic [1:0]  mode_sync;
	} dsc_link_s;

	dsc_link_s  s_q;
	dsc_link_s  s_d;
	logic [4:0] bit_count_q;
	logic       fall_out_q;

	// Select high clears the count with no clock edge needed
	always_ff @(posedge serial_clock or posedge chip_select_n) begin
		if (chip_select_n) begin
			bit_count_q <= 5'h00;
		end else if (bit_count_q != LINK_BITS_FULL) begin
			bit_count_q <= bit_count_q + 5'h01;
		end
	end

	always_comb begin
		s_d = s_q;
		s_d.mode_sync = {s_q.mode_sync[0], out_on_rise};
		if (!chip_select_n) begin
			s_d.shift = {s_q.shift[14:0], serial_data_in};
			// Bits past the sixteenth only shift through
			if (bit_count_q == LINK_BITS_LAST) begin
				s_d.word   = {s_q.shift[14:0], serial_data_in};
				s_d.toggle = !s_q.toggle;
			end
		end
	end

	always_ff @(posedge serial_clock or posedge link_rst) begin
		if (link_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	always_ff @(negedge serial_clock or posedge link_rst) begin
		if (link_rst) begin
			fall_out_q <= 1'b0;
		end else begin
			fall_out_q <= s_q.shift[15];
		end
	end

	assign serial_data_out = s_q.mode_sync[1] ? s_q.shift[15] : fall_out_q;
	assign word_data       = s_q.word;
	assign word_toggle     = s_q.toggle;
endmodule // dsc_serial_link
`default_nettype wire

// file: core/dsc_sync.sv
// Two-stage level synchroniser for a bundle of asynchronous inputs
`timescale 1ns/10ps
`default_nettype none
module dsc_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] safe;
	} dsc_sync_s;

	dsc_sync_s s_q;
	dsc_sync_s s_d;

	if (WIDTH < 1) begin : g_bad_width
		$error("dsc_sync: WIDTH must be at least 1");
	end

	always_comb begin
		s_d.meta = async_in;
		s_d.safe = s_q.meta;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sync_out = s_q.safe;
endmodule // dsc_sync
`default_nettype wire

// file: sim/dsc_core_tb.sv
// Self-checking bench of the serial converter control block
`timescale 1ns/10ps
`default_nettype none
module dsc_core_tb import dsc_pkg::*;;
	logic        clock, sys_rst, serial_clock, chip_select_n, serial_data_in;
	logic        serial_data_out, reset_value_select, shutdown_lockout_n;
	logic        clear_to_reset_value, power_down_request, user_general_output;
	logic        analog_drive_en, in_shutdown, reg_write, reg_read;
	logic [11:0] dac_code;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, rd, got, m_sh;
	int          error_cnt, compares, cyc, seed, m_dac, m_inp, m_rst, d;
	bit          m_sd, m_upo, m_lk, m_en, m_rise, m_ms;
	logic [2:0]  ops [7];

	dsc_host_model u_dsc_host_model (
		.serial_clock(serial_clock), .chip_select_n(chip_select_n),
		.serial_data_in(serial_data_in), .serial_data_out(serial_data_out));

	dsc_core u_dsc_core (
		.clock(clock), .sys_rst(sys_rst), .serial_clock(serial_clock),
		.chip_select_n(chip_select_n), .serial_data_in(serial_data_in),
		.serial_data_out(serial_data_out), .reset_value_select(reset_value_select),
		.shutdown_lockout_n(shutdown_lockout_n), .clear_to_reset_value(clear_to_reset_value),
		.power_down_request(power_down_request), .user_general_output(user_general_output),
		.dac_code(dac_code), .analog_drive_en(analog_drive_en), .in_shutdown(in_shutdown),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata));

	always #5 clock = ~clock;

	task automatic complete_run;
		$display("counts: compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Hang guard, far above the few thousand cycles the run needs
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			complete_run;
		end
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic chk_code(input string n, input int e, input logic [15:0] g);
		compares++;
		if (g !== e[15:0]) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", n, e[15:0], g);
		end
	endtask

	task automatic chk_bit(input string n, input bit e, input logic g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s expected %b seen %b", n, e, g);
		end
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clock);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic reg_rd(input logic [3:0] a);
		@(posedge clock);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 rd = reg_rdata;
	endtask

	task automatic check_all(input string t);
		chk_code("dac_code", m_dac, {4'h0, dac_code});
		chk_bit("in_shutdown", m_sd, in_shutdown);
		chk_bit("analog_drive_en", !m_sd, analog_drive_en);
		chk_bit("user_general_output", m_upo, user_general_output);
		reg_rd(REG_INPUT);
		chk_code("input_code", m_inp, rd);
		reg_rd(REG_STATUS);
		chk_code("status", {11'h000, m_rst != 0, m_lk, m_rise, m_upo, m_sd}, rd);
		$display("test %s done", t);
	endtask

	// Word effect lands a few system cycles after the last serial rise
	task automatic cmd(input logic [2:0] c, input logic [11:0] v);
		logic [15:0] e;
		u_dsc_host_model.send({c, v, 1'b0}, 16, got);
		// Output shows the previous word; its first bit still uses the old edge
		e = m_rise ? {m_sh[14:0], c[2]} : m_sh;
		e[15] = m_ms ? m_sh[14] : m_sh[15];
		chk_code("serial_data_out", e, got);
		m_sh = {c, v, 1'b0};
		m_ms = m_rise;
		wait_clk(10);
		if (m_en) begin
			case (c)
				CMD_LOAD_INPUT: m_inp = v;
				CMD_LOAD_BOTH: begin
					m_inp = v;
					m_dac = v;
					m_sd = 0;
				end
				CMD_UPDATE: begin
					m_dac = m_inp;
					m_sd = 0;
				end
				CMD_SHUTDOWN: m_sd = m_sd | m_lk;
				CMD_UOUT_HIGH: m_upo = 1;
				CMD_UOUT_LOW: m_upo = 0;
				CMD_DOUT_MODE: m_rise = v[11];
				default: ;
			endcase
		end
	endtask

	task automatic pins(input bit lk, input bit pd, input bit cl);
		@(posedge clock);
		if (m_sd && m_lk && !lk) begin
			m_sd = 0;
		end
		if (pd && lk) begin
			m_sd = 1;
		end
		if (cl) begin
			m_dac = m_rst;
			m_inp = m_rst;
			m_sd = 0;
		end
		m_lk = lk;
		shutdown_lockout_n <= lk;
		power_down_request <= pd;
		clear_to_reset_value <= cl;
		wait_clk(6);
	endtask

	initial begin
		ops = '{CMD_LOAD_INPUT, CMD_UPDATE, CMD_LOAD_BOTH, CMD_UOUT_HIGH,
			CMD_UOUT_LOW, CMD_NOP, CMD_DOUT_MODE};
		seed = 92576;
		clock = 1'b0;
		sys_rst = 1'b1;
		reset_value_select = 1'b1;
		shutdown_lockout_n = 1'b1;
		clear_to_reset_value = 1'b0;
		power_down_request = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_write = 1'b0;
		reg_read = 1'b0;
		m_rst = 'h800;
		m_dac = m_rst;
		m_inp = m_rst;
		m_lk = 1;
		m_en = 1;
		m_sh = 16'h0000;
		wait_clk(5);
		sys_rst <= 1'b0;
		wait_clk(12);
		check_all("reset");
		reg_rd(REG_CTRL);
		chk_code("ctrl", 1, rd);
		reg_rd(4'h9);
		chk_code("unmapped", 0, rd);
		for (int i = 0; i < 14; i++) begin
			d = $random(seed);
			cmd(ops[i % 7], d[11:0]);
			check_all("command");
		end
		u_dsc_host_model.send(16'h5ff0, 8, got);
		m_sh = {m_sh[7:0], 8'h5f};
		u_dsc_host_model.idle(4);
		m_ms = m_rise;
		wait_clk(10);
		reg_wr(REG_CTRL, 16'h0000);
		reg_wr(REG_DAC, 16'h0123);
		m_en = 0;
		cmd(CMD_LOAD_BOTH, 12'h5a5);
		check_all("refused");
		reg_wr(REG_CTRL, 16'h0001);
		m_en = 1;
		pins(0, 1, 0);
		check_all("lockout holds");
		pins(1, 1, 0);
		check_all("pin shutdown");
		pins(1, 0, 0);
		check_all("pin released");
		pins(0, 0, 0);
		check_all("lockout wake");
		pins(1, 0, 0);
		cmd(CMD_SHUTDOWN, 12'h000);
		check_all("soft shutdown");
		cmd(CMD_LOAD_INPUT, 12'h3c3);
		check_all("load in shutdown");
		pins(1, 0, 1);
		check_all("clear");
		pins(1, 0, 0);
		reset_value_select <= 1'b0;
		m_rst = 0;
		cmd(CMD_LOAD_BOTH, 12'hfff);
		pins(1, 0, 1);
		check_all("clear zero");
		pins(0, 0, 0);
		cmd(CMD_SHUTDOWN, 12'h000);
		check_all("shutdown refused");
		complete_run;
	end
endmodule // dsc_core_tb
`default_nettype wire

// file: sim/dsc_host_model.sv
// Host serial master driving the converter's four-wire link
`timescale 1ns/10ps
`default_nettype none
module dsc_host_model (
	output logic      serial_clock,
	output logic      chip_select_n,
	output logic      serial_data_in,
	input  wire logic serial_data_out
);
	initial begin
		serial_clock = 1'b0;
		chip_select_n = 1'b1;
		serial_data_in = 1'b0;
	end
	// Clock stands low between frames; released data shows the inverse
	task automatic send(input logic [15:0] w, input int nbits, output logic [15:0] got);
		#3;
		chip_select_n = 1'b0;
		#24;
		for (int i = 0; i < nbits; i++) begin
			serial_data_in = w[15-i];
			#24 serial_clock = 1'b1;
			// Read mid-high so the two output edges give different bits
			#12 got = {got[14:0], serial_data_out};
			#12 serial_clock = 1'b0;
		end
		serial_data_in = ~serial_data_in;
		chip_select_n = 1'b1;
		#48;
	endtask

	// Stray pulses with select high must be ignored
	task automatic idle(input int n);
		for (int i = 0; i < n; i++) begin
			serial_data_in = ~serial_data_in;
			#24 serial_clock = 1'b1;
			#24 serial_clock = 1'b0;
		end
	endtask
endmodule // dsc_host_model
`default_nettype wire
